// [common/bmmc_pkg.sv]
// Constants and types for the battery monitor memory command layer.
// Operation
// RULE1: 11h then address streams scratchpad bytes to page end; reserved bits read one.
// RULE2: At page end the next byte read is CRC8 of all bytes read.
// RULE3: After the CRC every further read returns ones until bus reset.
// RULE4: 17h then address stores written bytes into scratchpad up to page end.
// RULE5: 22h copies 24 scratch_page_one bytes to eeprom_page_one when unlocked.
// RULE6: nv_copy_busy_flag stays high during an EEPROM copy, then clears.
// RULE7: 25h copies 8 scratch_page_two bytes to eeprom_page_two, busy flag set.
// RULE8: 28h copies 8 scratch_page_three bytes to SRAM, no busy flag.
// RULE9: 71h copies eeprom_page_one to scratch_page_one, locked or not.
// RULE10: 77h copies eeprom_page_two to scratch_page_two.
// RULE11: 7Ah copies SRAM to scratch_page_three.
// RULE12: EEPROM and SRAM are reached only through scratchpad copies.
// RULE13: 43h sets the page one lock and raises nv_copy_busy_flag.
// RULE14: 44h clears the page one lock and raises nv_copy_busy_flag.
// RULE15: D2h starts temperature conversion with busy flag; result loads on completion.
// RULE16: B4h starts voltage conversion with busy flag; result loads on completion.
// RULE17: B2h then address reads registers; past 78h or 83h read ones.
// RULE18: B5h increments the cycle counter and raises nv_copy_busy_flag.
// RULE19: B8h clears the cycle counter and raises nv_copy_busy_flag.
// RULE20: Master sends nothing after copy, lock, counter or conversion commands.
// RULE21: Temperature conversion finishes within one second.
// RULE22: Voltage conversion finishes within ten milliseconds.
// RULE23: Temperature and voltage conversions never run together.
// RULE24: Unknown commands are ignored until the next bus reset.
// RULE25: Busy flags are readable in the status register byte.
package bmmc_pkg;
  localparam logic [7:0] CMD_RD_SP = 8'h11, CMD_WR_SP = 8'h17, CMD_CP_SP1 = 8'h22,
    CMD_CP_SP2 = 8'h25, CMD_CP_SP3 = 8'h28, CMD_LD_NV1 = 8'h71, CMD_LD_NV2 = 8'h77,
    CMD_LD_SRAM = 8'h7A, CMD_LOCK = 8'h43, CMD_UNLOCK = 8'h44, CMD_CONV_T = 8'hD2,
    CMD_CONV_V = 8'hB4, CMD_RD_REG = 8'hB2, CMD_CYC_INC = 8'hB5, CMD_CYC_CLR = 8'hB8;
  localparam int P1_BYTES = 24;
  localparam int P23_BYTES = 8;
  localparam int SP_DEPTH = 96;
  localparam int PAGE2_BASE = 32;
  localparam int PAGE3_BASE = 64;
  localparam logic [4:0] PAGE_LAST = 5'h1F;
  localparam logic [7:0] REG_TEMP_LO = 8'h60, REG_TEMP_HI = 8'h61, REG_VOLT_LO = 8'h62,
    REG_VOLT_HI = 8'h63, REG_STATUS = 8'h77, REG_P4_END = 8'h78, REG_CYC_LO = 8'h80,
    REG_CYC_HI = 8'h81, REG_ID_LO = 8'h82, REG_P5_END = 8'h83;
  localparam int ST_NV = 0;
  localparam int ST_TEMP = 1;
  localparam int ST_VOLT = 2;
  localparam int ST_LOCK = 3;
  localparam logic [7:0] CRC_POLY = 8'h8C;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] ONES = 8'hFF;
  localparam logic LOCK_RST = 1'b0;
  localparam logic [15:0] CYC_RST = 16'h0000;
  // Value is arbitrary.
  localparam logic [15:0] ID_DEFAULT = 16'h5A3C;
  localparam int CLK_KHZ = 200000;
  localparam int NV_WRITE_MS = 5;
  localparam int TEMP_CONV_MS = 1000;
  localparam int VOLT_CONV_MS = 10;
  localparam int NV_WRITE_CYC = NV_WRITE_MS * CLK_KHZ;
  localparam int TEMP_CONV_CYC = TEMP_CONV_MS * CLK_KHZ;
  localparam int VOLT_CONV_CYC = VOLT_CONV_MS * CLK_KHZ;
  localparam int FIFO_DEPTH = 8;
  localparam int BYTE_W = 8;
  typedef enum logic [2:0] {
    S_CMD = 3'b000, S_ADDR = 3'b001, S_RDSP = 3'b010,
    S_WRSP = 3'b011, S_RDREG = 3'b100, S_WAIT = 3'b101
  } bmmc_state_t;
  typedef enum logic [1:0] {PH_DATA = 2'b00, PH_CRC = 2'b01, PH_ONES = 2'b10} bmmc_phase_t;
  typedef struct packed {
    logic lock;
    logic voltBusy;
    logic tempBusy;
    logic nvBusy;
  } bmmc_stat_t;
  typedef struct packed {
    logic [15:0] temp;
    logic [9:0] volt;
  } bmmc_samp_t;
endpackage

// [rtl/bmmc_top.sv]
// Memory command layer with its read-data FIFO.
`timescale 1ns/1ps

// ==========================================================
// Read data FIFO
// Shift FIFO so the head word always sits in a flip-flop.
module bmmc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // Clock and control
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic flush,
  // Fill side
  input wire logic inValid,
  input wire logic [W-1:0] inData,
  output logic inReady,
  // Drain side
  output logic outValid,
  output logic [W-1:0] outData,
  input wire logic outReady
);
  localparam int CW = $clog2(D) + 1;
  localparam logic [CW-1:0] FULL = CW'(D);
  logic [W-1:0] mem [D];
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic validR;
  logic push;
  logic pop;

  // Handshakes and occupancy.
  assign inReady = (cnt_r != FULL);
  assign push = inValid && inReady;
  assign pop = validR && outReady;
  assign outValid = validR;
  assign outData = mem[0];
  assign cnt_nxt = cnt_r + CW'(push) - CW'(pop);

  // Count and valid flag track each other.
  always_ff @(posedge clock) begin
    if (rst || (ce && flush)) begin
      cnt_r <= '0;
      validR <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      validR <= (cnt_nxt != '0);
    end
  end

  // Each entry shifts down on pop and takes the new word at the tail.
  for (genvar i = 0; i < D; i++) begin : gEntry
    always_ff @(posedge clock) begin
      if (ce) begin
        if (pop) begin
          if (push && (CW'(i + 1) == cnt_r)) begin
            mem[i] <= inData;
          end else if (i < D - 1) begin
            mem[i] <= mem[(i < D - 1) ? i + 1 : i];
          end
        end else if (push && (CW'(i) == cnt_r)) begin
          mem[i] <= inData;
        end
      end
    end
  end
endmodule

// ==========================================================
// Command layer top
module bmmc_top #(
  parameter int NV_CYC = bmmc_pkg::NV_WRITE_CYC,
  parameter int TEMP_CYC = bmmc_pkg::TEMP_CONV_CYC,
  parameter int VOLT_CYC = bmmc_pkg::VOLT_CONV_CYC,
  // Value is arbitrary.
  parameter logic [15:0] DEVICE_ID = bmmc_pkg::ID_DEFAULT
) (
  // Clock and control
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Byte link from the bit-slot layer
  input wire logic busReset,
  input wire logic rxValid,
  input wire logic [7:0] rxByte,
  // Read bytes toward the bit-slot layer
  output logic txValid,
  output logic [7:0] txByte,
  input wire logic txReady,
  // Analog front end results
  input wire bmmc_pkg::bmmc_samp_t convSample,
  // Status
  output bmmc_pkg::bmmc_stat_t status
);
  bmmc_pkg::bmmc_state_t state_r;
  bmmc_pkg::bmmc_phase_t phase_r;
  logic [7:0] cmd_r;
  logic [7:0] addr_r;
  logic [7:0] crc_r;
  logic [7:0] sp_r [bmmc_pkg::SP_DEPTH];
  logic [7:0] nv1_r [bmmc_pkg::P1_BYTES];
  logic [7:0] nv2_r [bmmc_pkg::P23_BYTES];
  logic [7:0] sram_r [bmmc_pkg::P23_BYTES];
  logic lock_r;
  logic nvBusy_r;
  logic [20:0] nvCnt_r;
  logic [15:0] cyc_r;
  logic tempBusy_r;
  logic voltBusy_r;
  logic [27:0] convCnt_r;
  logic [15:0] tempReg_r;
  logic [9:0] voltReg_r;
  bmmc_pkg::bmmc_samp_t samp1_r;
  bmmc_pkg::bmmc_samp_t samp2_r;
  bmmc_pkg::bmmc_samp_t samp3_r;
  bmmc_pkg::bmmc_samp_t sampHeld_r;
  logic cmdGo;
  logic nvFree;
  logic convFree;
  logic pushValid;
  logic pushReady;
  logic pushed;
  logic [7:0] pushData;
  logic [7:0] spByte;
  logic [7:0] regByte;
  logic [7:0] statByte;
  logic known;

  // One CRC8 step per byte, reflected polynomial.
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ b[i]) begin
        r = (r >> 1) ^ bmmc_pkg::CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  // True where a scratchpad byte really exists.
  function automatic logic spValid(input logic [7:0] a);
    logic [4:0] off;
    off = a[4:0];
    if (a[7:5] == 3'd0) begin
      return 32'(off) < bmmc_pkg::P1_BYTES;
    end
    return (a[7:5] < 3'd3) && (32'(off) < bmmc_pkg::P23_BYTES);
  endfunction

  // Command decode shared by the scratchpad, store, lock and conversion processes.
  assign cmdGo = ce && rxValid && (state_r == bmmc_pkg::S_CMD);
  assign nvFree = !nvBusy_r;
  assign convFree = !tempBusy_r && !voltBusy_r;
  assign status = '{lock: lock_r, voltBusy: voltBusy_r, tempBusy: tempBusy_r,
                    nvBusy: nvBusy_r};

  // Analog results pass two flip-flops; a word is kept once it stands for two cycles.
  always_ff @(posedge clock) begin
    if (ce) begin
      samp1_r <= convSample;
      samp2_r <= samp1_r;
      samp3_r <= samp2_r;
      if (samp2_r == samp3_r) begin
        sampHeld_r <= samp2_r;
      end
    end
  end

  // Status byte and register space read mux; reserved bits read as ones.
  always_comb begin
    statByte = bmmc_pkg::ONES;
    statByte[bmmc_pkg::ST_NV] = nvBusy_r; // RULE25
    statByte[bmmc_pkg::ST_TEMP] = tempBusy_r; // RULE25
    statByte[bmmc_pkg::ST_VOLT] = voltBusy_r; // RULE25
    statByte[bmmc_pkg::ST_LOCK] = lock_r;
    case (addr_r)
      bmmc_pkg::REG_TEMP_LO: regByte = tempReg_r[7:0];
      bmmc_pkg::REG_TEMP_HI: regByte = tempReg_r[15:8];
      bmmc_pkg::REG_VOLT_LO: regByte = voltReg_r[7:0];
      bmmc_pkg::REG_VOLT_HI: regByte = {6'h3F, voltReg_r[9:8]};
      bmmc_pkg::REG_STATUS: regByte = statByte;
      bmmc_pkg::REG_CYC_LO: regByte = cyc_r[7:0];
      bmmc_pkg::REG_CYC_HI: regByte = cyc_r[15:8];
      bmmc_pkg::REG_ID_LO: regByte = DEVICE_ID[7:0];
      bmmc_pkg::REG_P5_END: regByte = DEVICE_ID[15:8];
      default: regByte = bmmc_pkg::ONES; // RULE17
    endcase
  end

  // Read byte producer: data, then CRC for scratchpad reads only, then ones.
  assign spByte = spValid(addr_r) ? sp_r[addr_r[6:0]] : bmmc_pkg::ONES; // RULE1
  assign pushValid = ce && ((state_r == bmmc_pkg::S_RDSP) || (state_r == bmmc_pkg::S_RDREG));
  assign pushed = pushValid && pushReady;
  always_comb begin
    if (phase_r == bmmc_pkg::PH_ONES) begin
      pushData = bmmc_pkg::ONES; // RULE3
    end else if (state_r == bmmc_pkg::S_RDREG) begin
      pushData = regByte; // RULE17
    end else if (phase_r == bmmc_pkg::PH_CRC) begin
      pushData = crc_r; // RULE2
    end else begin
      pushData = spByte;
    end
  end

  // Known command bytes; anything else parks the layer.
  always_comb begin
    case (rxByte)
      bmmc_pkg::CMD_RD_SP, bmmc_pkg::CMD_WR_SP, bmmc_pkg::CMD_RD_REG,
      bmmc_pkg::CMD_CP_SP1, bmmc_pkg::CMD_CP_SP2, bmmc_pkg::CMD_CP_SP3,
      bmmc_pkg::CMD_LD_NV1, bmmc_pkg::CMD_LD_NV2, bmmc_pkg::CMD_LD_SRAM,
      bmmc_pkg::CMD_LOCK, bmmc_pkg::CMD_UNLOCK, bmmc_pkg::CMD_CONV_T,
      bmmc_pkg::CMD_CONV_V, bmmc_pkg::CMD_CYC_INC, bmmc_pkg::CMD_CYC_CLR: known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  // Transaction sequencer; a bus reset aborts whatever is under way.
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= bmmc_pkg::S_WAIT;
      phase_r <= bmmc_pkg::PH_DATA;
      cmd_r <= 8'h00;
      addr_r <= 8'h00;
      crc_r <= bmmc_pkg::CRC_INIT;
    end else if (ce && busReset) begin
      state_r <= bmmc_pkg::S_CMD;
      phase_r <= bmmc_pkg::PH_DATA;
    end else if (ce) begin
      case (state_r)
        bmmc_pkg::S_CMD: begin
          if (rxValid) begin
            cmd_r <= rxByte;
            crc_r <= bmmc_pkg::CRC_INIT;
            if ((rxByte == bmmc_pkg::CMD_RD_SP) || (rxByte == bmmc_pkg::CMD_WR_SP) ||
                (rxByte == bmmc_pkg::CMD_RD_REG)) begin
              state_r <= bmmc_pkg::S_ADDR;
            end else begin
              state_r <= bmmc_pkg::S_WAIT; // RULE20 RULE24
            end
          end
        end
        bmmc_pkg::S_ADDR: begin
          if (rxValid) begin
            addr_r <= rxByte;
            if (cmd_r == bmmc_pkg::CMD_RD_SP) begin
              state_r <= bmmc_pkg::S_RDSP; // RULE1
            end else if (cmd_r == bmmc_pkg::CMD_WR_SP) begin
              state_r <= bmmc_pkg::S_WRSP; // RULE4
            end else begin
              state_r <= bmmc_pkg::S_RDREG; // RULE17
            end
          end
        end
        bmmc_pkg::S_RDSP: begin
          if (pushed && (phase_r == bmmc_pkg::PH_DATA)) begin
            crc_r <= crc8(crc_r, spByte); // RULE2
            addr_r <= addr_r + 8'h01;
            if (addr_r[4:0] == bmmc_pkg::PAGE_LAST) begin
              phase_r <= bmmc_pkg::PH_CRC; // RULE2
            end
          end else if (pushed && (phase_r == bmmc_pkg::PH_CRC)) begin
            phase_r <= bmmc_pkg::PH_ONES; // RULE3
          end
        end
        bmmc_pkg::S_RDREG: begin
          if (pushed) begin
            addr_r <= addr_r + 8'h01;
            if ((addr_r == bmmc_pkg::REG_P4_END) || (addr_r == bmmc_pkg::REG_P5_END)) begin
              phase_r <= bmmc_pkg::PH_ONES; // RULE17
            end
          end
        end
        bmmc_pkg::S_WRSP: begin
          if (rxValid) begin
            addr_r <= addr_r + 8'h01;
            if (addr_r[4:0] == bmmc_pkg::PAGE_LAST) begin
              state_r <= bmmc_pkg::S_WAIT; // RULE4
            end
          end
        end
        default: state_r <= state_r;
      endcase
    end
  end

  // Scratchpad: master writes and loads from the stores behind it.
  always_ff @(posedge clock) begin
    if (ce && !busReset) begin
      if ((state_r == bmmc_pkg::S_WRSP) && rxValid && spValid(addr_r)) begin
        sp_r[addr_r[6:0]] <= rxByte; // RULE4
      end
      if (cmdGo && (rxByte == bmmc_pkg::CMD_LD_NV1)) begin
        for (int i = 0; i < bmmc_pkg::P1_BYTES; i++) begin
          sp_r[i] <= nv1_r[i]; // RULE9
        end
      end
      if (cmdGo && (rxByte == bmmc_pkg::CMD_LD_NV2)) begin
        for (int i = 0; i < bmmc_pkg::P23_BYTES; i++) begin
          sp_r[bmmc_pkg::PAGE2_BASE + i] <= nv2_r[i]; // RULE10
        end
      end
      if (cmdGo && (rxByte == bmmc_pkg::CMD_LD_SRAM)) begin
        for (int i = 0; i < bmmc_pkg::P23_BYTES; i++) begin
          sp_r[bmmc_pkg::PAGE3_BASE + i] <= sram_r[i]; // RULE11
        end
      end
    end
  end

  // Stores reachable only by copy from the scratchpad.
  always_ff @(posedge clock) begin
    if (cmdGo && nvFree && !lock_r && (rxByte == bmmc_pkg::CMD_CP_SP1)) begin
      for (int i = 0; i < bmmc_pkg::P1_BYTES; i++) begin
        nv1_r[i] <= sp_r[i]; // RULE5 RULE12
      end
    end
    if (cmdGo && nvFree && (rxByte == bmmc_pkg::CMD_CP_SP2)) begin
      for (int i = 0; i < bmmc_pkg::P23_BYTES; i++) begin
        nv2_r[i] <= sp_r[bmmc_pkg::PAGE2_BASE + i]; // RULE7
      end
    end
    if (cmdGo && (rxByte == bmmc_pkg::CMD_CP_SP3)) begin
      for (int i = 0; i < bmmc_pkg::P23_BYTES; i++) begin
        sram_r[i] <= sp_r[bmmc_pkg::PAGE3_BASE + i]; // RULE8
      end
    end
  end

  // Lock, cycle counter and the nonvolatile write timer.
  always_ff @(posedge clock) begin
    if (rst) begin
      lock_r <= bmmc_pkg::LOCK_RST;
      cyc_r <= bmmc_pkg::CYC_RST;
      nvBusy_r <= 1'b0;
      nvCnt_r <= '0;
    end else if (ce) begin
      if (cmdGo && nvFree && ((rxByte == bmmc_pkg::CMD_CP_SP1 && !lock_r) ||
          rxByte == bmmc_pkg::CMD_CP_SP2 || rxByte == bmmc_pkg::CMD_LOCK ||
          rxByte == bmmc_pkg::CMD_UNLOCK || rxByte == bmmc_pkg::CMD_CYC_INC ||
          rxByte == bmmc_pkg::CMD_CYC_CLR)) begin
        nvBusy_r <= 1'b1; // RULE6 RULE7 RULE13 RULE14 RULE18 RULE19
        nvCnt_r <= 21'(NV_CYC - 1);
        if (rxByte == bmmc_pkg::CMD_LOCK) begin
          lock_r <= 1'b1; // RULE13
        end
        if (rxByte == bmmc_pkg::CMD_UNLOCK) begin
          lock_r <= 1'b0; // RULE14
        end
        if (rxByte == bmmc_pkg::CMD_CYC_INC) begin
          cyc_r <= cyc_r + 16'h0001; // RULE18
        end
        if (rxByte == bmmc_pkg::CMD_CYC_CLR) begin
          cyc_r <= 16'h0000; // RULE19
        end
      end else if (nvBusy_r) begin
        if (nvCnt_r == '0) begin
          nvBusy_r <= 1'b0; // RULE6
        end else begin
          nvCnt_r <= nvCnt_r - 21'h000001;
        end
      end
    end
  end

  // Conversion timer shared by both kinds, which never overlap.
  always_ff @(posedge clock) begin
    if (rst) begin
      tempBusy_r <= 1'b0;
      voltBusy_r <= 1'b0;
      convCnt_r <= '0;
      tempReg_r <= 16'h0000;
      voltReg_r <= 10'h000;
    end else if (ce) begin
      if (cmdGo && convFree && (rxByte == bmmc_pkg::CMD_CONV_T)) begin
        tempBusy_r <= 1'b1; // RULE15 RULE23
        convCnt_r <= 28'(TEMP_CYC - 1); // RULE21
      end else if (cmdGo && convFree && (rxByte == bmmc_pkg::CMD_CONV_V)) begin
        voltBusy_r <= 1'b1; // RULE16 RULE23
        convCnt_r <= 28'(VOLT_CYC - 1); // RULE22
      end else if (tempBusy_r || voltBusy_r) begin
        if (convCnt_r == '0) begin
          tempBusy_r <= 1'b0;
          voltBusy_r <= 1'b0;
          if (tempBusy_r) begin
            tempReg_r <= sampHeld_r.temp; // RULE15
          end else begin
            voltReg_r <= sampHeld_r.volt; // RULE16
          end
        end else begin
          convCnt_r <= convCnt_r - 28'h0000001;
        end
      end
    end
  end

  // Read bytes wait here for the bit-slot layer; a full FIFO stalls the producer.
  bmmc_fifo #(.W(bmmc_pkg::BYTE_W), .D(bmmc_pkg::FIFO_DEPTH)) uFifo (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .flush(busReset),
    .inValid(pushValid),
    .inData(pushData),
    .inReady(pushReady),
    .outValid(txValid),
    .outData(txByte),
    .outReady(txReady)
  );

  // ==========================================================
  // Checks
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  a_copy_nv_busy: assert property (cmdGo && nvFree && !lock_r && rxByte == bmmc_pkg::CMD_CP_SP1
    |=> nvBusy_r) else $error("copy did not raise busy"); // RULE5
  a_locked_copy_refused: assert property (cmdGo && nvFree && lock_r &&
    rxByte == bmmc_pkg::CMD_CP_SP1 |=> !nvBusy_r) else $error("locked copy ran"); // RULE13
  a_lock_sets: assert property (cmdGo && nvFree && rxByte == bmmc_pkg::CMD_LOCK
    |=> lock_r && nvBusy_r) else $error("lock not recorded"); // RULE13
  a_unlock_clears: assert property (cmdGo && nvFree && rxByte == bmmc_pkg::CMD_UNLOCK
    |=> !lock_r && nvBusy_r) else $error("unlock not recorded"); // RULE14
  a_cycle_incr: assert property (cmdGo && nvFree && rxByte == bmmc_pkg::CMD_CYC_INC
    |=> cyc_r == $past(cyc_r) + 16'h0001) else $error("cycle count not advanced"); // RULE18
  a_cycle_clear: assert property (cmdGo && nvFree && rxByte == bmmc_pkg::CMD_CYC_CLR
    |=> cyc_r == 16'h0000) else $error("cycle count not cleared"); // RULE19
  a_conv_exclusive: assert property (!(tempBusy_r && voltBusy_r))
    else $error("conversions overlap"); // RULE23
  a_temp_start: assert property (cmdGo && convFree && rxByte == bmmc_pkg::CMD_CONV_T
    |=> tempBusy_r && !voltBusy_r) else $error("temperature busy missing"); // RULE15
  a_ones_tail: assert property (pushed && phase_r == bmmc_pkg::PH_ONES
    |-> pushData == bmmc_pkg::ONES) else $error("ones tail broken"); // RULE3
  a_crc_after_page: assert property (pushed && state_r == bmmc_pkg::S_RDSP &&
    phase_r == bmmc_pkg::PH_DATA && addr_r[4:0] == bmmc_pkg::PAGE_LAST && !busReset
    |=> phase_r == bmmc_pkg::PH_CRC) else $error("no CRC after page end"); // RULE2
  a_unknown_parks: assert property (cmdGo && !busReset && !known
    |=> state_r == bmmc_pkg::S_WAIT) else $error("unknown command acted"); // RULE24

  c_scratch_read: cover property (pushed && phase_r == bmmc_pkg::PH_CRC);
  c_copy_done: cover property (nvBusy_r ##1 !nvBusy_r);
  c_fifo_full: cover property (pushValid && !pushReady);
  c_volt_done: cover property (voltBusy_r ##1 !voltBusy_r);
endmodule

// [verif/bmmc_host_model.sv]
// Host-side byte model: bus resets, writes, and reads with random stalls.
`timescale 1ns/1ps
module bmmc_host_model (
  // Clock
  input wire logic clock,
  // Bytes toward the device
  output logic busReset,
  output logic rxValid,
  output logic [7:0] rxByte,
  // Bytes from the device
  input wire logic txValid,
  input wire logic [7:0] txByte,
  output logic txReady
);
  logic want = 1'b0;
  // ==========================================================
  // Drivers
  // Idle values at time zero.
  initial begin
    busReset = 1'b0;
    rxValid = 1'b0;
    rxByte = 8'h00;
  end
  // Ready is withheld at random, so the FIFO sees a slow reader.
  always @(negedge clock) txReady <= want && ($urandom_range(0, 2) != 0);
  // One-cycle bus reset pulse.
  task automatic pulseReset();
    @(negedge clock) busReset = 1'b1;
    @(negedge clock) busReset = 1'b0;
  endtask
  // One byte for one cycle; afterwards the line shows the inverse, not stale data.
  task automatic sendByte(input logic [7:0] b);
    @(negedge clock) rxByte = b;
    rxValid = 1'b1;
    @(negedge clock) rxValid = 1'b0;
    rxByte = ~b;
  endtask
  // Pops one byte at the edge where valid and ready are both high, within a bound.
  task automatic recvByte(output logic [7:0] b, output bit ok);
    ok = 1'b0;
    b = 8'h00;
    want = 1'b1;
    for (int i = 0; i < 300 && !ok; i++) begin
      @(posedge clock);
      ok = (txValid === 1'b1 && txReady === 1'b1);
      b = txByte;
    end
    want = 1'b0;
  endtask
endmodule

// [verif/tb.sv]
// Bench for the memory command layer, checked against a reference model.
`timescale 1ns/1ps
module tb;
  localparam int NVC = 20;
  localparam int TC = 50;
  localparam int VC = 30;
  // Value is arbitrary.
  localparam logic [15:0] ID = 16'hC3A5;
  localparam logic [7:0] CPY [3] = '{8'h22, 8'h25, 8'h28};
  localparam logic [7:0] LDC [3] = '{8'h71, 8'h77, 8'h7A};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic busReset, rxValid, txValid, txReady;
  logic [7:0] rxByte, txByte;
  bmmc_pkg::bmmc_samp_t convSample = '0;
  bmmc_pkg::bmmc_stat_t status;
  int miscompares = 0;
  int comparisons = 0;
  // Reference state: scratchpad, the two EEPROM pages and SRAM, registers.
  logic [7:0] sp [96];
  logic [7:0] nv [3][24];
  logic [15:0] cyc = 16'h0000;
  logic [15:0] tmp = 16'h0000;
  logic [9:0] vlt = 10'h000;
  logic [3:0] stx = 4'h0;
  // ==========================================================
  // Clock and instances
  // Free-running 200 MHz clock.
  initial forever #2.5 clock = ~clock;
  bmmc_top #(.NV_CYC(NVC), .TEMP_CYC(TC), .VOLT_CYC(VC), .DEVICE_ID(ID)) u_dut (
    .clock(clock), .rst(rst), .ce(ce), .busReset(busReset), .rxValid(rxValid),
    .rxByte(rxByte), .txValid(txValid), .txByte(txByte), .txReady(txReady),
    .convSample(convSample), .status(status));
  bmmc_host_model u_host (.clock(clock), .busReset(busReset), .rxValid(rxValid),
    .rxByte(rxByte), .txValid(txValid), .txByte(txByte), .txReady(txReady));
  // ==========================================================
  // Model and checks
  // Reflected CRC8 with polynomial 8Ch, one byte.
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    c = c ^ d;
    for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ 8'h8C) : (c >> 1);
    return c;
  endfunction
  // Real bytes in a page; the rest of the 32 are reserved.
  function automatic int psz(input int p);
    return (p == 0) ? 24 : 8;
  endfunction
  // Expected register byte at an address.
  function automatic logic [7:0] regVal(input int a);
    case (a)
      8'h60: return tmp[7:0];
      8'h61: return tmp[15:8];
      8'h62: return vlt[7:0];
      8'h63: return {6'h3F, vlt[9:8]};
      8'h77: return {4'hF, stx};
      8'h80: return cyc[7:0];
      8'h81: return cyc[15:8];
      8'h82: return ID[7:0];
      8'h83: return ID[15:8];
      default: return 8'hFF;
    endcase
  endfunction
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Compares a flag or value seen at the ports.
  task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  // Pops one read byte and compares it; a timeout ends the run.
  task automatic chkRd(input string what, input logic [7:0] e);
    logic [7:0] g;
    bit ok;
    u_host.recvByte(g, ok);
    if (!ok) begin
      miscompares++;
      $display("mismatch %s expected %h seen timeout", what, e);
      stop_test();
    end else begin
      cmp(what, e, g);
    end
  endtask
  // Bus reset, then a command byte.
  task automatic cmd(input logic [7:0] c);
    u_host.pulseReset();
    u_host.sendByte(c);
  endtask
  // A busy flag stays high for its time, then drops within a few cycles.
  task automatic holdDrop(input int idx, input int n);
    repeat (n - 2) @(negedge clock);
    cmp("busy held", 8'h01, 8'(status[idx]));
    for (int i = 0; i < 6 && status[idx] !== 1'b0; i++) @(negedge clock);
    cmp("busy cleared", 8'h00, 8'(status[idx]));
  endtask
  // Writes a whole page with random bytes; reserved places keep reading ones.
  task automatic wrPage(input int p);
    logic [7:0] d;
    cmd(8'h17);
    u_host.sendByte(8'(p * 32));
    for (int i = 0; i < 32; i++) begin
      d = 8'($urandom);
      u_host.sendByte(d);
      if (i < psz(p)) sp[p * 32 + i] = d;
    end
  endtask
  // Reads from an offset to the page end, after a stall that fills the FIFO.
  task automatic rdPage(input int p, input int s);
    logic [7:0] c, e;
    c = 8'h00;
    cmd(8'h11);
    u_host.sendByte(8'(p * 32 + s));
    ce = 1'b0;
    repeat (4) @(negedge clock);
    cmp("frozen fifo", 8'h00, 8'(txValid));
    ce = 1'b1;
    repeat (20) @(negedge clock);
    for (int i = s; i < 32; i++) begin
      e = (i < psz(p)) ? sp[p * 32 + i] : 8'hFF;
      c = crc8(c, e);
      chkRd("scratch byte", e);
    end
    chkRd("page crc", c);
    chkRd("after crc", 8'hFF);
    chkRd("after crc", 8'hFF);
  endtask
  // Reads registers from an address.
  task automatic rdRegs(input int a, input int n);
    cmd(8'hB2);
    u_host.sendByte(8'(a));
    for (int i = 0; i < n; i++) chkRd("register", regVal(a + i));
  endtask
  // Copy a page out, overwrite the scratchpad, copy it back and read it.
  task automatic pageTest(input int p);
    wrPage(p);
    if (stx[3] !== 1'b1) for (int i = 0; i < psz(p); i++) nv[p][i] = sp[p * 32 + i];
    cmd(CPY[p]);
    if (p < 2 && stx[3] !== 1'b1) holdDrop(bmmc_pkg::ST_NV, NVC);
    else cmp("copy busy", 8'h00, 8'(status[bmmc_pkg::ST_NV]));
    wrPage(p);
    cmd(LDC[p]);
    for (int i = 0; i < psz(p); i++) sp[p * 32 + i] = nv[p][i];
    rdPage(p, p * 3);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(6));
    repeat (8) @(negedge clock);
    rst = 1'b0;
    convSample = 26'($urandom);
    for (int p = 0; p < 3; p++) pageTest(p);
    $display("test page copies done");
    cmd(8'h43);
    holdDrop(bmmc_pkg::ST_NV, NVC);
    stx = 4'h8;
    rdRegs(8'h77, 1);
    cmd(8'h22);
    @(negedge clock);
    cmp("locked copy busy", 8'h00, 8'(status[bmmc_pkg::ST_NV]));
    pageTest(0);
    cmd(8'h44);
    holdDrop(bmmc_pkg::ST_NV, NVC);
    stx = 4'h0;
    pageTest(0);
    $display("test lock done");
    for (int k = 0; k < 2; k++) begin
      cmd(8'hB5);
      cmd(8'hB5);
      holdDrop(bmmc_pkg::ST_NV, NVC - 4);
      cyc++;
    end
    rdRegs(8'h80, 6);
    cmd(8'hB8);
    holdDrop(bmmc_pkg::ST_NV, NVC);
    cyc = 16'h0000;
    rdRegs(8'h7F, 3);
    $display("test counter done");
    cmd(8'hD2);
    cmd(8'hB4);
    cmp("volt idle", 8'h00, 8'(status[bmmc_pkg::ST_VOLT]));
    holdDrop(bmmc_pkg::ST_TEMP, TC - 4);
    tmp = convSample.temp;
    cmd(8'hB4);
    holdDrop(bmmc_pkg::ST_VOLT, VC);
    vlt = convSample.volt;
    cmd(8'hD2);
    stx = 4'h2;
    rdRegs(8'h77, 3);
    repeat (TC) @(negedge clock);
    stx = 4'h0;
    cmp("temp done", 8'h00, 8'(status[bmmc_pkg::ST_TEMP]));
    rdRegs(8'h60, 4);
    cmd(8'h5A);
    u_host.sendByte(8'h11);
    u_host.sendByte(8'h00);
    repeat (10) @(negedge clock);
    cmp("ignored command", 8'h00, 8'(txValid));
    $display("test conversions and unknown command done");
    stop_test();
  end
endmodule
